/* File: bench/otpsp_prog_model.sv */
// Behavioural programmer that drives the serial programming pins
`timescale 1ns/1ps
`default_nettype none
module otpsp_prog_model (
  // Clock
  input wire logic clk_i,
  // Pins toward the device
  output logic vpp_o,
  output logic cs_n_o,
  output logic sck_o,
  output logic rnw_o,
  output logic [3:0] dout_o,
  output logic drive_o,
  // Resolved bus and device enable
  input wire logic [3:0] bus_i,
  input wire logic dev_oe_n_i
);
  logic [15:0] q [0:1];
  int bad = 0;
  initial begin
    vpp_o = 1'b0;
    cs_n_o = 1'b1;
    sck_o = 1'b1;
    rnw_o = 1'b0;
    dout_o = 4'h0;
    drive_o = 1'b0;
  end
  task automatic set_vpp(input logic v);
    @(posedge clk_i);
    vpp_o <= v;
    repeat (6) @(posedge clk_i);
  endtask : set_vpp
  // Called on a rising edge; 8 clk a nibble gives a 400 ns serial clock
  // Data holds to the rise, since the port latches it three cycles after the fall
  task automatic nib(input logic drv, input logic [3:0] d, output logic [3:0] s);
    drive_o <= drv;
    dout_o <= d;
    repeat (4) @(posedge clk_i);
    sck_o <= 1'b0;
    s = bus_i;
    if (drv && dev_oe_n_i !== 1'b1) bad++;
    repeat (4) @(posedge clk_i);
    sck_o <= 1'b1;
  endtask : nib
  // Ignored nibble bits are sent as ones to prove they are ignored
  task automatic frame(input logic rd, input logic ts, input logic os, input logic [10:0] a,
                       input logic [13:0] d, input int nw);
    logic [3:0] s;
    logic [15:0] w16;
    logic [15:0] d16;
    d16 = {2'b11, d};
    @(posedge clk_i);
    rnw_o <= rd;
    cs_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    nib(1'b1, a[3:0], s);
    nib(1'b1, a[7:4], s);
    nib(1'b1, {1'b1, a[10:8]}, s);
    nib(1'b1, {os, ts, 2'b11}, s);
    for (int w = 0; w < nw; w++) begin
      for (int k = 0; k < 4; k++) begin
        nib(!rd, d16[4*k +: 4], s);
        w16[4*k +: 4] = s;
      end
      q[w] = w16;
    end
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    drive_o <= 1'b0;
    repeat (30) @(posedge clk_i);
  endtask : frame
  task automatic loose(input logic csn, input int n);
    logic [3:0] s;
    @(posedge clk_i);
    rnw_o <= 1'b0;
    cs_n_o <= csn;
    repeat (6) @(posedge clk_i);
    for (int i = 0; i < n; i++) nib(1'b1, 4'hA, s);
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : loose
endmodule : otpsp_prog_model
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the serial programming port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import otpsp_pkg::*;
  typedef struct packed {logic rd; logic ts; logic os; logic [10:0] a; logic [13:0] d;} otpsp_row_t;
  localparam otpsp_row_t ROWS [10] = '{
    '{1'b0, 1'b0, 1'b0, 11'h7FF, 14'h2A5C},
    '{1'b0, 1'b0, 1'b0, 11'h000, 14'h1234},
    '{1'b0, 1'b0, 1'b0, 11'h001, 14'h0ABC},
    '{1'b0, 1'b0, 1'b0, 11'h000, 14'h0001},
    '{1'b1, 1'b0, 1'b0, 11'h7FF, 14'h2A5C},
    '{1'b1, 1'b0, 1'b0, 11'h000, 14'h1235},
    '{1'b1, 1'b1, 1'b0, 11'h003, 14'h0003},
    '{1'b0, 1'b0, 1'b1, 11'h000, 14'h0055},
    '{1'b1, 1'b0, 1'b1, 11'h000, 14'h0055},
    '{1'b1, 1'b1, 1'b1, 11'h000, 14'h0000}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic vpp, cs_n, sck, rnw, mdrive, oe_n, active, busy;
  logic [3:0] mdata, dout, bus;
  logic [ADDR_W-1:0] addr;
  int errors = 0;
  int n_checks = 0;
  always #25 clk_i = ~clk_i;
  // Port A lines are pulled high when nobody drives them
  assign bus = (oe_n === 1'b0) ? dout : (mdrive ? mdata : 4'hF);
  otpsp_prog_model u_otpsp_prog_model (.clk_i(clk_i), .vpp_o(vpp), .cs_n_o(cs_n), .sck_o(sck), .rnw_o(rnw),
    .dout_o(mdata), .drive_o(mdrive), .bus_i(bus), .dev_oe_n_i(oe_n));
  otpsp_port u_otpsp_port (.clk_i(clk_i), .rst_i(rst_i), .prog_voltage_i(vpp), .chip_select_n_i(cs_n),
    .serial_clk_i(sck), .read_not_write_i(rnw), .nibble_bus_lines_i(bus), .nibble_bus_lines_o(dout),
    .nibble_bus_lines_oe_n_o(oe_n), .active_o(active), .addr_o(addr), .wr_busy_o(busy));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("oe_n idle", 16'h1, {15'h0, oe_n});
    chk("active idle", 16'h0, {15'h0, active});
    chk("addr reset", 16'h0, {5'h0, addr});
    u_otpsp_prog_model.set_vpp(1'b1);
    foreach (ROWS[i]) begin
      u_otpsp_prog_model.frame(ROWS[i].rd, ROWS[i].ts, ROWS[i].os, ROWS[i].a, ROWS[i].d, 1);
      if (ROWS[i].rd) chk("word", {2'b00, ROWS[i].d}, u_otpsp_prog_model.q[0]);
      if (!ROWS[i].ts && !ROWS[i].os) chk("addr", {5'h0, ROWS[i].a + 11'(ROWS[i].rd)}, {5'h0, addr});
    end
    // Two words in one frame without resending the address
    fork
      u_otpsp_prog_model.frame(1'b1, 1'b0, 1'b0, 11'h000, 14'h0, 2);
      begin
        repeat (20) @(posedge clk_i);
        chk("active in frame", 16'h1, {15'h0, active});
      end
    join
    chk("inc word0", 16'h1235, u_otpsp_prog_model.q[0]);
    chk("inc word1", 16'h0ABC, u_otpsp_prog_model.q[1]);
    chk("inc addr", 16'h0002, {5'h0, addr});
    u_otpsp_prog_model.loose(1'b1, 4);
    chk("deselected edges", 16'h0002, {5'h0, addr});
    u_otpsp_prog_model.loose(1'b0, 2);
    u_otpsp_prog_model.frame(1'b1, 1'b0, 1'b0, 11'h001, 14'h0, 1);
    chk("after abort", 16'h0ABC, u_otpsp_prog_model.q[0]);
    u_otpsp_prog_model.set_vpp(1'b0);
    u_otpsp_prog_model.frame(1'b0, 1'b0, 1'b0, 11'h002, 14'h3FFF, 1);
    u_otpsp_prog_model.set_vpp(1'b1);
    u_otpsp_prog_model.frame(1'b1, 1'b0, 1'b0, 11'h002, 14'h0, 1);
    chk("no vpp write", 16'h0000, u_otpsp_prog_model.q[0]);
    u_otpsp_prog_model.frame(1'b0, 1'b0, 1'b1, 11'h000, 14'h2000, 1);
    u_otpsp_prog_model.frame(1'b1, 1'b0, 1'b0, 11'h000, 14'h0, 1);
    chk("locked read", 16'h3FFF, u_otpsp_prog_model.q[0]);
    chk("bus contention", 16'h0, 16'(u_otpsp_prog_model.bad));
    chk("spare status", 16'h0, {15'h0, busy});
    // Reset again in mid-run: address and bus return to idle
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("addr mid reset", 16'h0, {5'h0, addr});
    chk("oe_n mid reset", 16'h1, {15'h0, oe_n});
    chk("active mid reset", 16'h0, {15'h0, active});
    stop_test();
  end
  // A hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

/* File: rtl/otpsp_fifo.sv */
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
`default_nettype none
module otpsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill and drain sides
  otpsp_fifo_if.snk in_if,
  otpsp_fifo_if.src out_if
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_if.ready = (cnt_reg != (PW+1)'(DEPTH));
  assign out_if.valid = (cnt_reg != '0);
  assign out_if.data = mem_reg[rptr_reg];
  assign push = in_if.valid & in_if.ready;
  assign pop = out_if.valid & out_if.ready;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_if.data;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == PW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == PW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
  chk_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_reg <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : otpsp_fifo
`default_nettype wire

/* File: rtl/otpsp_fifo_if.sv */
// Handshake carrier between the port logic and its write FIFO
`timescale 1ns/1ps
`default_nettype none
interface otpsp_fifo_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : otpsp_fifo_if
`default_nettype wire

/* File: rtl/otpsp_pkg.sv */
// Package for the one-time-programmable memory serial programming port
package otpsp_pkg;
  localparam int ADDR_W = 11;
  localparam int CODE_W = 14;
  localparam int NIB_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int PROG_DEPTH = 2048;
  localparam int TEST_DEPTH = 16;
  localparam logic [1:0] NIB_FIRST = 2'h0;
  localparam logic [1:0] NIB_LAST = 2'h3;
  localparam int TEST_MEMORY_SELECT_BIT = 2;
  localparam int OPTION_MEMORY_SELECT_BIT = 3;
  localparam int LOCK_BIT = 13;
  localparam logic [CODE_W-1:0] CODE_BLANK = 14'h0000;
  localparam logic [CODE_W-1:0] CODE_LOCKED = 14'h3FFF;
  typedef enum logic [1:0] {OTPSP_PROG, OTPSP_OPT, OTPSP_TEST, OTPSP_NONE} otpsp_mem_t;
  typedef struct packed {
    otpsp_mem_t mem;
    logic [ADDR_W-1:0] addr;
    logic [CODE_W-1:0] data;
  } otpsp_wr_t;
endpackage : otpsp_pkg

/* File: rtl/otpsp_port.sv */
// Serial nibble programming and verification port of the OTP program memory
`timescale 1ns/1ps
`default_nettype none
module otpsp_port
  import otpsp_pkg::*;
#(
  parameter int FIFO_D = otpsp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Programming pins, all asynchronous to clk_i
  input wire logic prog_voltage_i,
  input wire logic chip_select_n_i,
  input wire logic serial_clk_i,
  input wire logic read_not_write_i,
  input wire logic [otpsp_pkg::NIB_W-1:0] nibble_bus_lines_i,
  output logic [otpsp_pkg::NIB_W-1:0] nibble_bus_lines_o,
  output logic nibble_bus_lines_oe_n_o,
  // Status
  output logic active_o,
  output logic [otpsp_pkg::ADDR_W-1:0] addr_o,
  output logic wr_busy_o
);
  import otpsp_pkg::*;

  typedef enum logic {OTPSP_ADDR, OTPSP_DATA} otpsp_phase_t;
  localparam int WR_W = $bits(otpsp_wr_t);

  logic [1:0] cs_sync_reg, clk_sync_reg, rw_sync_reg, vpp_sync_reg;
  logic [NIB_W-1:0] nib_s1_reg, nib_s2_reg;
  logic clk_prev_reg;
  logic [1:0] nib_cnt_reg;
  otpsp_phase_t phase_reg;
  logic [ADDR_W-1:0] addr_reg;
  otpsp_mem_t mem_reg;
  logic [CODE_W-1:0] shift_reg;
  logic [CODE_W-1:0] prog_mem [PROG_DEPTH];
  logic [PROG_DEPTH-1:0] used_reg;
  logic busy_reg;
  logic [CODE_W-1:0] opt_reg;
  logic [CODE_W-1:0] test_mem [TEST_DEPTH];
  logic [NIB_W-1:0] dout_reg;
  logic oe_n_reg;
  logic active_reg;
  logic fall;
  logic sel;
  logic [CODE_W-1:0] rd_word;
  logic [CODE_W-1:0] wr_word;

  otpsp_fifo_if #(.WIDTH(WR_W)) wr_in ();
  otpsp_fifo_if #(.WIDTH(WR_W)) wr_out ();

  function automatic otpsp_mem_t decode_mem(input logic test_memory_select, input logic option_memory_select);
    unique case ({test_memory_select, option_memory_select})
      2'b10: decode_mem = OTPSP_TEST;
      2'b01: decode_mem = OTPSP_OPT;
      2'b00: decode_mem = OTPSP_PROG;
      default: decode_mem = OTPSP_NONE;
    endcase
  endfunction : decode_mem

  // Two-flop synchronisers on every pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_sync_reg <= 2'h3;
      clk_sync_reg <= 2'h3; // Idle high, so reset makes no false edge
      rw_sync_reg <= 2'h0;
      vpp_sync_reg <= 2'h0;
      nib_s1_reg <= 4'h0;
      nib_s2_reg <= 4'h0;
      clk_prev_reg <= 1'b1;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], chip_select_n_i};
      clk_sync_reg <= {clk_sync_reg[0], serial_clk_i};
      rw_sync_reg <= {rw_sync_reg[0], read_not_write_i};
      vpp_sync_reg <= {vpp_sync_reg[0], prog_voltage_i};
      nib_s1_reg <= nibble_bus_lines_i;
      nib_s2_reg <= nib_s1_reg;
      clk_prev_reg <= clk_sync_reg[1];
    end
  end

  assign fall = clk_prev_reg & ~clk_sync_reg[1];
  // Programming voltage gates entry; otherwise the pins are ordinary port lines
  assign sel = ~cs_sync_reg[1] & vpp_sync_reg[1];

  always_comb begin
    unique case (mem_reg)
      OTPSP_PROG: rd_word = used_reg[addr_reg] ? prog_mem[addr_reg] : CODE_BLANK;
      OTPSP_OPT: rd_word = opt_reg;
      OTPSP_TEST: rd_word = test_mem[addr_reg[3:0]];
      default: rd_word = CODE_BLANK;
    endcase
    if (opt_reg[LOCK_BIT] && mem_reg == OTPSP_PROG) begin
      rd_word = CODE_LOCKED;
    end
  end

  // Nibble sequencing and address/code capture
  always_ff @(posedge clk_i) begin
    if (rst_i || !sel) begin
      nib_cnt_reg <= NIB_FIRST;
      phase_reg <= OTPSP_ADDR;
    end else if (fall) begin
      nib_cnt_reg <= nib_cnt_reg + 2'h1;
      if (nib_cnt_reg == NIB_LAST) begin
        phase_reg <= OTPSP_DATA;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg <= '0;
      mem_reg <= OTPSP_PROG;
      shift_reg <= '0;
    end else if (sel && fall) begin
      if (phase_reg == OTPSP_ADDR) begin
        unique case (nib_cnt_reg)
          2'h0: addr_reg[3:0] <= nib_s2_reg;
          2'h1: addr_reg[7:4] <= nib_s2_reg;
          2'h2: addr_reg[10:8] <= nib_s2_reg[2:0];
          2'h3: mem_reg <= decode_mem(nib_s2_reg[TEST_MEMORY_SELECT_BIT], nib_s2_reg[OPTION_MEMORY_SELECT_BIT]);
        endcase
      end else begin
        unique case (nib_cnt_reg)
          2'h0: shift_reg[3:0] <= nib_s2_reg;
          2'h1: shift_reg[7:4] <= nib_s2_reg;
          2'h2: shift_reg[11:8] <= nib_s2_reg;
          2'h3: shift_reg[13:12] <= nib_s2_reg[1:0];
        endcase
        if (nib_cnt_reg == NIB_LAST && rw_sync_reg[1]) begin
          addr_reg <= addr_reg + 11'h001;
        end
      end
    end
  end

  // Write word completes on fourth data nibble; fifo decouples array update
  assign wr_word = {nib_s2_reg[1:0], shift_reg[11:0]};
  assign wr_in.valid = sel & fall & (phase_reg == OTPSP_DATA) & (nib_cnt_reg == NIB_LAST)
    & ~rw_sync_reg[1];
  assign wr_in.data = {mem_reg, addr_reg, wr_word};

  otpsp_fifo #(.WIDTH(WR_W), .DEPTH(FIFO_D)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_if(wr_in),
    .out_if(wr_out)
  );

  // OTP cells only go 0 to 1; one write drained per two cycles models slow programming
  logic drain_reg;
  otpsp_wr_t wr_q;
  assign wr_q = otpsp_wr_t'(wr_out.data);
  assign wr_out.ready = drain_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drain_reg <= 1'b0;
    end else begin
      drain_reg <= ~drain_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opt_reg <= CODE_BLANK;
    end else if (wr_out.valid && drain_reg && wr_q.mem == OTPSP_OPT) begin
      opt_reg <= opt_reg | wr_q.data;
    end
  end

  // Array has no reset; unwritten cells read blank through the used map
  always_ff @(posedge clk_i) begin
    if (wr_out.valid && drain_reg && wr_q.mem == OTPSP_PROG) begin
      prog_mem[wr_q.addr] <= (used_reg[wr_q.addr] ? prog_mem[wr_q.addr] : CODE_BLANK) | wr_q.data;
    end
  end

  // Reset stands in for a fresh blank part
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      used_reg <= '0;
    end else if (wr_out.valid && drain_reg && wr_q.mem == OTPSP_PROG) begin
      used_reg[wr_q.addr] <= 1'b1;
    end
  end

  // Test memory is read-only from the port
  initial begin
    for (int i = 0; i < TEST_DEPTH; i++) begin
      test_mem[i] = CODE_W'(i);
    end
  end

  // Read data is presented after the preceding falling edge, ready for the next
  always_ff @(posedge clk_i) begin
    if (rst_i || !sel) begin
      dout_reg <= 4'h0;
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= ~(phase_reg == OTPSP_DATA && rw_sync_reg[1]);
      unique case (nib_cnt_reg)
        2'h0: dout_reg <= rd_word[3:0];
        2'h1: dout_reg <= rd_word[7:4];
        2'h2: dout_reg <= rd_word[11:8];
        2'h3: dout_reg <= {2'b00, rd_word[13:12]};
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= sel;
    end
  end

  // Writes still queued for the array
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= wr_out.valid;
    end
  end

  assign nibble_bus_lines_o = dout_reg;
  assign nibble_bus_lines_oe_n_o = oe_n_reg;
  assign active_o = active_reg;
  assign addr_o = addr_reg;
  assign wr_busy_o = busy_reg;

  chk_top_zero_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    (!oe_n_reg && nib_cnt_reg == NIB_LAST && $past(nib_cnt_reg) == NIB_LAST && $past(sel))
    |-> dout_reg[3:2] == 2'b00) else $error("read top bits not zero");
  chk_deselect_float: assert property (@(posedge clk_i) disable iff (rst_i)
    !sel |=> oe_n_reg) else $error("bus driven while deselected");
  chk_counter_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    !sel |=> nib_cnt_reg == NIB_FIRST && phase_reg == OTPSP_ADDR) else $error("counter not restarted");
  chk_addr_increment: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel && fall && phase_reg == OTPSP_DATA && nib_cnt_reg == NIB_LAST && rw_sync_reg[1])
    |=> addr_reg == $past(addr_reg) + 11'h001) else $error("address not incremented");
  chk_write_no_incr: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel && fall && phase_reg == OTPSP_DATA && !rw_sync_reg[1]) |=> addr_reg == $past(addr_reg))
    else $error("address moved on write");
  chk_lock_ones: assert property (@(posedge clk_i) disable iff (rst_i)
    (opt_reg[LOCK_BIT] && mem_reg == OTPSP_PROG) |-> rd_word == CODE_LOCKED)
    else $error("locked read not all ones");
  chk_no_edge_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel && !fall) |=> nib_cnt_reg == $past(nib_cnt_reg)) else $error("counter moved without edge");
  chk_mem_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel && fall && phase_reg == OTPSP_ADDR && nib_cnt_reg == NIB_LAST && nib_s2_reg[3:2] == 2'b01)
    |=> mem_reg == OTPSP_TEST) else $error("test memory not selected");
  chk_addr_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel && fall && phase_reg == OTPSP_ADDR && nib_cnt_reg == 2'h2)
    |=> addr_reg[10:8] == $past(nib_s2_reg[2:0])) else $error("address high nibble wrong");
  chk_busy_pending: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_in.valid && wr_in.ready) |=> ##1 busy_reg) else $error("queued write not flagged busy");
endmodule : otpsp_port
`default_nettype wire
